// [rtl/smb_burst_gen.sv]
`timescale 1ns/1ns
`default_nettype none
module smb_burst_gen (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic go_i,
  input wire logic stop_i,
  input wire logic write_i,
  input wire logic interleave_i,
  input wire logic full_i,
  input wire logic [8:0] mask_i,
  input wire logic [8:0] start_i,
  output var smb_pkg::smb_beat_type beat_o,
  output logic busy_o
);
  import smb_pkg::*;

  typedef enum logic [1:0] {
    SMB_BG_IDLE = 2'b00,
    SMB_BG_RUN = 2'b01
  } smb_bg_state_type;

  smb_bg_state_type state_reg;
  logic [8:0] start_reg;
  logic [8:0] cnt_reg;
  logic [8:0] mask_reg;
  logic il_reg;
  logic wr_reg;
  logic full_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Column of beat cnt: offset wraps inside the block, block bits stay.
  function automatic logic [8:0] beat_col(input logic [8:0] start, input logic [8:0] cnt,
                                          input logic [8:0] mask, input logic il);
    logic [8:0] off;
    off = il ? ((start ^ cnt) & mask) : ((start + cnt) & mask);
    beat_col = (start & ~mask) | off;
  endfunction : beat_col

  always_comb
  begin
    beat_o = '0;
    if (go_i)
    begin
      beat_o.valid = 1'b1;
      beat_o.write = write_i;
      beat_o.col = start_i;
    end
    else if (state_reg == SMB_BG_RUN && !stop_i)
    begin
      beat_o.valid = 1'b1;
      beat_o.write = wr_reg;
      beat_o.col = beat_col(start_reg, cnt_reg, mask_reg, il_reg);
    end
  end

  assign busy_o = (state_reg == SMB_BG_RUN);

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      state_reg <= SMB_BG_IDLE;
      start_reg <= '0;
      cnt_reg <= '0;
      mask_reg <= '0;
      il_reg <= 1'b0;
      wr_reg <= 1'b0;
      full_reg <= 1'b0;
    end
    else if (go_i)
    begin
      start_reg <= start_i;
      mask_reg <= mask_i;
      il_reg <= interleave_i;
      wr_reg <= write_i;
      full_reg <= full_i;
      cnt_reg <= 9'h001;
      state_reg <= (mask_i == 9'h000) ? SMB_BG_IDLE : SMB_BG_RUN;
    end
    else if (state_reg == SMB_BG_RUN)
    begin
      cnt_reg <= cnt_reg + 9'h001;
      if (stop_i || (cnt_reg == mask_reg && !full_reg))
      begin
        state_reg <= SMB_BG_IDLE;
      end
    end
  end

endmodule : smb_burst_gen
`default_nettype wire

// [rtl/smb_pkg.sv]
`default_nettype none
package smb_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Column and burst geometry.
  localparam int SMB_COL_W = 9;
  localparam int SMB_FULL_PAGE_LEN = 512;
  localparam int SMB_ADDR_W = 13;

  // Base register field positions.
  localparam int SMB_BL_LSB = 0;
  localparam int SMB_BT_BIT = 3;
  localparam int SMB_LAT_LSB = 4;
  localparam int SMB_OPM_LO_BIT = 7;
  localparam int SMB_OPM_HI_BIT = 8;
  localparam int SMB_WS_BIT = 9;

  // Extended setup register field positions.
  localparam int SMB_PARTIAL_REFRESH_COVERAGE_LSB = 0;
  localparam int SMB_EXT_RSV_LO_LSB = 3;
  localparam int SMB_DRV_LSB = 5;
  localparam int SMB_EXT_RSV_HI_LSB = 8;

  // Burst length codes.
  localparam logic [2:0] SMB_BL_1 = 3'h0;
  localparam logic [2:0] SMB_BL_2 = 3'h1;
  localparam logic [2:0] SMB_BL_4 = 3'h2;
  localparam logic [2:0] SMB_BL_8 = 3'h3;
  localparam logic [2:0] SMB_BL_PAGE = 3'h7;

  // Self refresh coverage codes.
  localparam logic [2:0] SMB_PARTIAL_REFRESH_COVERAGE_ALL = 3'h0;
  localparam logic [2:0] SMB_PARTIAL_REFRESH_COVERAGE_HALF = 3'h1;
  localparam logic [2:0] SMB_PARTIAL_REFRESH_COVERAGE_QUARTER = 3'h2;
  localparam logic [2:0] SMB_PARTIAL_REFRESH_COVERAGE_EIGHTH = 3'h5;
  localparam logic [2:0] SMB_PARTIAL_REFRESH_COVERAGE_SIXTEENTH = 3'h6;

  // Drive codes and their strength in eighths of full.
  localparam logic [2:0] SMB_DRV_FULL = 3'h0;
  localparam logic [2:0] SMB_DRV_HALF = 3'h1;
  localparam logic [2:0] SMB_DRV_QUARTER = 3'h2;
  localparam logic [2:0] SMB_DRV_EIGHTH = 3'h3;
  localparam logic [2:0] SMB_DRV_3QUARTER = 3'h4;
  localparam logic [3:0] SMB_LVL_FULL = 4'h8;
  localparam logic [3:0] SMB_LVL_HALF = 4'h4;
  localparam logic [3:0] SMB_LVL_QUARTER = 4'h2;
  localparam logic [3:0] SMB_LVL_EIGHTH = 4'h1;
  localparam logic [3:0] SMB_LVL_3QUARTER = 4'h6;

  // Reset values.
  localparam logic [12:0] SMB_BASE_RESET = 13'h0020;
  localparam logic [12:0] SMB_EXT_RESET = 13'h0000;
  localparam logic [31:0] SMB_CTRL_RESET = 32'h0000_0000;

  // Register bus offsets and control bits.
  localparam logic [7:0] SMB_OFS_BASE = 8'h00;
  localparam logic [7:0] SMB_OFS_EXT = 8'h04;
  localparam logic [7:0] SMB_OFS_STATUS = 8'h08;
  localparam logic [7:0] SMB_OFS_CTRL = 8'h0c;
  localparam int SMB_CTRL_SREF_BIT = 0;

  // Self refresh timing at the 25 MHz clock.
  localparam int SMB_CLK_PERIOD_NS = 40;
  localparam int SMB_REFRESH_INTERVAL_NS = 7812;
  localparam int SMB_REFRESH_CYCLES = SMB_REFRESH_INTERVAL_NS / SMB_CLK_PERIOD_NS;

  ////////////////////////////////////////////////////////////////////////////
  typedef enum logic [2:0] {
    SMB_CMD_NOP = 3'h0,
    SMB_CMD_LOAD = 3'h1,
    SMB_CMD_READ = 3'h2,
    SMB_CMD_WRITE = 3'h3,
    SMB_CMD_TERMINATE = 3'h4
  } smb_cmd_kind_type;

  typedef struct packed {
    smb_cmd_kind_type kind;
    logic bank_select_high;
    logic bank_select_low;
    logic [12:0] addr;
  } smb_cmd_type;

  typedef struct packed {
    logic valid;
    logic write;
    logic [8:0] col;
  } smb_beat_type;

endpackage : smb_pkg
`default_nettype wire

// [rtl/smb_sequencer.sv]
// Our own choices: the Wishbone interface to the registers and the register addresses.
`timescale 1ns/1ns
`default_nettype none
module smb_sequencer (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire smb_pkg::smb_cmd_type cmd_i,
  input wire logic [1:0] temp_i,
  output var smb_pkg::smb_beat_type beat_o,
  output logic dq_drive_o,
  output logic dq_valid_o,
  output logic [8:0] dq_col_o,
  output logic [3:0] drive_level_o,
  output logic refresh_tick_o,
  output logic [3:0] refresh_banks_o,
  output logic [1:0] refresh_rows_o
);
  import smb_pkg::*;

  logic [12:0] base_reg;
  logic [12:0] ext_reg;
  logic [31:0] ctrl_reg;
  logic [31:0] rdata_reg;
  logic ack_reg;
  logic [7:0] ref_cnt_reg;
  logic tick_reg;
  logic [3:0] lvl_reg;
  logic [3:0] banks_reg;
  logic [1:0] rows_reg;
  logic [3:1] pipe_vld_reg;
  logic [8:0] pipe_col_reg [3:1];
  logic load_go, base_load, ext_load, mode_ok, lat_ok, busy, rd_iss, ext_rsv;
  logic burst_go, burst_stop, burst_write, burst_full, burst_il;
  logic [8:0] burst_mask;
  logic [2:0] bl_code, lat_code, partial_refresh_coverage_code, drv_code;
  logic [7:0] ref_limit;
  smb_beat_type beat_comb;

  ////////////////////////////////////////////////////////////////////////////
  // Block mask of a burst length code; all ones marks sequential full page.
  function automatic logic [8:0] len_mask(input logic [2:0] code, input logic il);
    len_mask = 9'h000;
    case (code)
      SMB_BL_2: len_mask = 9'h001;
      SMB_BL_4: len_mask = 9'h003;
      SMB_BL_8: len_mask = 9'h007;
      SMB_BL_PAGE: len_mask = il ? 9'h000 : 9'(SMB_FULL_PAGE_LEN - 1);
      default: len_mask = 9'h000;
    endcase
  endfunction : len_mask

  function automatic logic len_legal(input logic [2:0] code, input logic il);
    len_legal = (code <= SMB_BL_8) || (code == SMB_BL_PAGE && !il);
  endfunction : len_legal

  function automatic logic lat_legal(input logic [2:0] code);
    lat_legal = (code >= 3'h1) && (code <= 3'h3);
  endfunction : lat_legal

  ////////////////////////////////////////////////////////////////////////////
  // Mode field decode.
  assign bl_code = base_reg[SMB_BL_LSB +: 3];
  assign lat_code = base_reg[SMB_LAT_LSB +: 3];
  assign burst_il = base_reg[SMB_BT_BIT];
  assign partial_refresh_coverage_code = ext_reg[SMB_PARTIAL_REFRESH_COVERAGE_LSB +: 3];
  assign drv_code = ext_reg[SMB_DRV_LSB +: 3];
  assign ext_rsv = (ext_reg[SMB_EXT_RSV_LO_LSB +: 2] != 2'h0) ||
                   (ext_reg[12:SMB_EXT_RSV_HI_LSB] != 5'h00);
  assign mode_ok = !base_reg[SMB_OPM_LO_BIT] && !base_reg[SMB_OPM_HI_BIT] &&
                   len_legal(bl_code, burst_il);
  assign lat_ok = lat_legal(lat_code);

  ////////////////////////////////////////////////////////////////////////////
  // Command decode.
  assign load_go = (cmd_i.kind == SMB_CMD_LOAD);
  assign ext_load = load_go && cmd_i.bank_select_high && !cmd_i.bank_select_low;
  assign base_load = load_go && !cmd_i.bank_select_high && !cmd_i.bank_select_low;
  assign burst_write = (cmd_i.kind == SMB_CMD_WRITE);
  assign burst_go = mode_ok && (burst_write || (cmd_i.kind == SMB_CMD_READ && lat_ok));
  assign burst_stop = (cmd_i.kind == SMB_CMD_TERMINATE);
  assign burst_full = (bl_code == SMB_BL_PAGE) && !(burst_write && base_reg[SMB_WS_BIT]);
  assign burst_mask = (burst_write && base_reg[SMB_WS_BIT]) ? 9'h000
                                                          : len_mask(bl_code, burst_il);

  smb_burst_gen u_burst (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .go_i(burst_go),
    .stop_i(burst_stop),
    .write_i(burst_write),
    .interleave_i(burst_il && !burst_full),
    .full_i(burst_full),
    .mask_i(burst_mask),
    .start_i(cmd_i.addr[8:0]),
    .beat_o(beat_comb),
    .busy_o(busy)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Mode registers.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      base_reg <= SMB_BASE_RESET;
    else if (base_load)
      base_reg <= cmd_i.addr;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      ext_reg <= SMB_EXT_RESET;
    else if (ext_load)
      ext_reg <= cmd_i.addr;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Beat output and read latency pipeline.
  assign rd_iss = beat_comb.valid && !beat_comb.write;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      beat_o <= '0;
    else
      beat_o <= beat_comb;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      pipe_vld_reg[1] <= 1'b0;
      pipe_col_reg[1] <= '0;
    end
    else
    begin
      pipe_vld_reg[1] <= rd_iss;
      pipe_col_reg[1] <= beat_comb.col;
    end
  end

  for (genvar i = 2; i <= 3; i++)
  begin : g_pipe
    always_ff @(posedge clk_i)
    begin
      if (rst_i)
      begin
        pipe_vld_reg[i] <= 1'b0;
        pipe_col_reg[i] <= '0;
      end
      else
      begin
        pipe_vld_reg[i] <= pipe_vld_reg[i - 1];
        pipe_col_reg[i] <= pipe_col_reg[i - 1];
      end
    end
  end

  always_comb
  begin
    dq_drive_o = 1'b0;
    dq_valid_o = 1'b0;
    dq_col_o = '0;
    case (lat_code)
      3'h1:
      begin
        dq_drive_o = rd_iss;
        dq_valid_o = pipe_vld_reg[1];
        dq_col_o = pipe_col_reg[1];
      end
      3'h2:
      begin
        dq_drive_o = pipe_vld_reg[1];
        dq_valid_o = pipe_vld_reg[2];
        dq_col_o = pipe_col_reg[2];
      end
      3'h3:
      begin
        dq_drive_o = pipe_vld_reg[2];
        dq_valid_o = pipe_vld_reg[3];
        dq_col_o = pipe_col_reg[3];
      end
      default: dq_drive_o = 1'b0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Drive strength and self refresh coverage.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      lvl_reg <= SMB_LVL_FULL;
    else
      case (drv_code)
        SMB_DRV_HALF: lvl_reg <= SMB_LVL_HALF;
        SMB_DRV_QUARTER: lvl_reg <= SMB_LVL_QUARTER;
        SMB_DRV_EIGHTH: lvl_reg <= SMB_LVL_EIGHTH;
        SMB_DRV_3QUARTER: lvl_reg <= SMB_LVL_3QUARTER;
        default: lvl_reg <= SMB_LVL_FULL;
      endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      {banks_reg, rows_reg} <= {4'hf, 2'h0};
    else
      case (partial_refresh_coverage_code)
        SMB_PARTIAL_REFRESH_COVERAGE_HALF: {banks_reg, rows_reg} <= {4'h3, 2'h0};
        SMB_PARTIAL_REFRESH_COVERAGE_QUARTER: {banks_reg, rows_reg} <= {4'h1, 2'h0};
        SMB_PARTIAL_REFRESH_COVERAGE_EIGHTH: {banks_reg, rows_reg} <= {4'h1, 2'h1};
        SMB_PARTIAL_REFRESH_COVERAGE_SIXTEENTH: {banks_reg, rows_reg} <= {4'h1, 2'h2};
        default: {banks_reg, rows_reg} <= {4'hf, 2'h0};
      endcase
  end

  // Hotter sensor codes shorten the interval by powers of two.
  assign ref_limit = 8'(SMB_REFRESH_CYCLES) >> temp_i;

  always_ff @(posedge clk_i)
  begin
    if (rst_i || !ctrl_reg[SMB_CTRL_SREF_BIT])
    begin
      ref_cnt_reg <= '0;
      tick_reg <= 1'b0;
    end
    else if (ref_cnt_reg >= ref_limit - 8'h01)
    begin
      ref_cnt_reg <= '0;
      tick_reg <= 1'b1;
    end
    else
    begin
      ref_cnt_reg <= ref_cnt_reg + 8'h01;
      tick_reg <= 1'b0;
    end
  end

  assign drive_level_o = lvl_reg;
  assign refresh_tick_o = tick_reg;
  assign refresh_banks_o = banks_reg;
  assign refresh_rows_o = rows_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Wishbone slave: one wait state, write lands on the acknowledged edge.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      ack_reg <= 1'b0;
    else
      ack_reg <= wb_cyc_i && wb_stb_i && !ack_reg;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      rdata_reg <= '0;
    else if (wb_adr_i == SMB_OFS_BASE)
      rdata_reg <= {19'h00000, base_reg};
    else if (wb_adr_i == SMB_OFS_EXT)
      rdata_reg <= {19'h00000, ext_reg};
    else if (wb_adr_i == SMB_OFS_STATUS)
      rdata_reg <= {7'h00, beat_o.col, 13'h0000, ext_rsv, !(mode_ok && lat_ok), busy};
    else if (wb_adr_i == SMB_OFS_CTRL)
      rdata_reg <= ctrl_reg;
    else
      rdata_reg <= '0;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      ctrl_reg <= SMB_CTRL_RESET;
    else if (ack_reg && wb_cyc_i && wb_stb_i && wb_we_i && wb_sel_i[0] &&
             wb_adr_i == SMB_OFS_CTRL)
      ctrl_reg <= {31'h00000000, wb_dat_i[SMB_CTRL_SREF_BIT]};
  end

  assign wb_ack_o = ack_reg;
  assign wb_dat_o = rdata_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Checks.
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_ext_load_value: assert property (ext_load |=> ext_reg == $past(cmd_i.addr))
    else $error("extended register not loaded");
  a_ext_keeps_base: assert property (ext_load |=> $stable(base_reg))
    else $error("extended load changed base register");
  a_ext_holds: assert property (!ext_load |=> $stable(ext_reg))
    else $error("extended register changed without load");
  a_lat_one: assert property (rd_iss && lat_code == 3'h1 |-> dq_drive_o ##1 dq_valid_o)
    else $error("latency one timing wrong");
  a_lat_two: assert property (rd_iss && lat_code == 3'h2 && !load_go |=> dq_drive_o &&
                              dq_valid_o == $past(rd_iss, 2) ##1 dq_valid_o)
    else $error("latency two timing wrong");
  a_lat_three: assert property (rd_iss && lat_code == 3'h3 && !load_go |=>
                                dq_drive_o == $past(rd_iss, 2) ##1 dq_drive_o ##1 dq_valid_o)
    else $error("latency three timing wrong");
  a_single_col: assert property (burst_go && bl_code == SMB_BL_1
                                 |=> beat_o.valid && beat_o.col == $past(cmd_i.addr[8:0]))
    else $error("length one column wrong");
  a_write_single: assert property (burst_go && burst_write && base_reg[SMB_WS_BIT]
                                   |=> beat_o.valid ##1 !busy)
    else $error("single write ran a burst");
  a_opmode_block: assert property (!mode_ok && !busy |=> !beat_o.valid)
    else $error("burst started in reserved mode");
  a_block_eight: assert property (busy && bl_code == SMB_BL_8 && beat_comb.valid && !burst_go
                                  |-> beat_comb.col[8:3] == beat_o.col[8:3])
    else $error("length eight burst left its block");
  a_page_step: assert property (busy && burst_full && beat_comb.valid && !burst_go
                                && beat_o.valid |-> beat_comb.col == beat_o.col + 9'h001)
    else $error("full page burst skipped a column");
  a_partial_refresh_coverage_half: assert property (partial_refresh_coverage_code == SMB_PARTIAL_REFRESH_COVERAGE_HALF |=> refresh_banks_o == 4'h3)
    else $error("half coverage mask wrong");
  a_drive_half: assert property (drv_code == SMB_DRV_HALF |=> drive_level_o == SMB_LVL_HALF)
    else $error("half drive level wrong");

  c_read_burst: cover property (burst_go && !burst_write && bl_code == SMB_BL_8);
  c_full_page_wrap: cover property (busy && burst_full && beat_o.col == 9'h1ff);
  c_interleave: cover property (burst_go && burst_il && bl_code == SMB_BL_4);
  c_refresh_tick: cover property (refresh_tick_o);

endmodule : smb_sequencer
`default_nettype wire

// [test/smb_ctrl_model.sv]
`timescale 1ns/1ns
`default_nettype none
module smb_ctrl_model (
  input wire logic clk_i,
  output var smb_pkg::smb_cmd_type cmd_o
);
  import smb_pkg::*;
  // Sends one command per call and NOP otherwise; the clock stays at 25 MHz.
  // Extended loads carry zero reserved bits, latency codes stay legal.
  // Loads are only sent between bursts, with idle cycles after them.
  initial cmd_o = '0;
  task automatic send(input smb_cmd_kind_type k, input logic bh, input logic [12:0] a);
    @(posedge clk_i);
    cmd_o <= '{k, bh, 1'b0, a};
    @(posedge clk_i);
    cmd_o <= '{SMB_CMD_NOP, 1'b0, 1'b0, 13'h0000};
  endtask : send
endmodule : smb_ctrl_model
`default_nettype wire

// [test/smb_sequencer_tb.sv]
`timescale 1ns/1ns
`default_nettype none
module smb_sequencer_tb;
  import smb_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0;
  logic [31:0] wb_dat_o, rd;
  logic wb_ack_o, dq_drive_o, dq_valid_o, refresh_tick_o;
  logic [8:0] dq_col_o;
  logic [3:0] drive_level_o, refresh_banks_o;
  logic [1:0] temp_i = 2'h0;
  logic [1:0] refresh_rows_o;
  smb_cmd_type cmd_i;
  smb_beat_type beat_o;
  int err_count = 0, checks = 0, i, q, b, n0, n1;
  logic [3:0] lv [5] = '{SMB_LVL_FULL, SMB_LVL_HALF, SMB_LVL_QUARTER, SMB_LVL_EIGHTH,
    SMB_LVL_3QUARTER};
  logic [2:0] pc [5] = '{3'h0, 3'h1, 3'h2, 3'h5, 3'h6};
  logic [5:0] pm [5] = '{6'h3c, 6'h0c, 6'h04, 6'h05, 6'h06};

  smb_ctrl_model u_ctrl (.clk_i(clk_i), .cmd_o(cmd_i));
  smb_sequencer u_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .cmd_i(cmd_i), .temp_i(temp_i), .beat_o(beat_o),
    .dq_drive_o(dq_drive_o), .dq_valid_o(dq_valid_o), .dq_col_o(dq_col_o),
    .drive_level_o(drive_level_o), .refresh_tick_o(refresh_tick_o),
    .refresh_banks_o(refresh_banks_o), .refresh_rows_o(refresh_rows_o));

  initial
  begin
    forever #20 clk_i = ~clk_i;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic close_out();
    $display("checks %0d errors %0d", checks, err_count);
    if (err_count == 0 && checks > 0)
    begin
      $display("== PASSED ==");
    end
    else
    begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : close_out

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_sel_i <= 4'hf;
    wb_dat_i <= d;
    for (k = 0; k < 20; k++)
    begin
      @(posedge clk_i);
      if (wb_ack_o === 1'b1)
        break;
    end
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
    wb_sel_i <= 4'h0;
    if (k == 20)
    begin
      err_count++;
      close_out();
    end
  endtask : wb

  task automatic wait_tick(output int n);
    for (n = 1; n < 400; n++)
    begin
      @(posedge clk_i);
      #1;
      if (refresh_tick_o === 1'b1)
        return;
    end
    err_count++;
    close_out();
  endtask : wait_tick

  function automatic logic [12:0] md(logic ws, logic [1:0] op, logic [2:0] lat, logic bt,
    logic [2:0] bl);
    return {3'h0, ws, op, lat, bt, bl};
  endfunction : md

  function automatic logic [8:0] ecol(logic [8:0] s, int len, logic il, int k);
    logic [8:0] m;
    m = 9'(len - 1);
    return (s & ~m) | ((il ? (s ^ 9'(k)) : (s + 9'(k))) & m);
  endfunction : ecol

  // Checks n beats of a burst, then that no further beat follows; a full page burst is first sent a terminate and is checked idle after it.
  task automatic burst(input smb_cmd_kind_type k, input logic [8:0] s, input int len,
    input logic il, input int n);
    int j;
    u_ctrl.send(k, 1'b0, {4'h0, s});
    for (j = 0; j < n; j++)
    begin
      #1;
      chk(beat_o.valid, 1'b1);
      chk(beat_o.col, ecol(s, len, il, j));
      chk(beat_o.write, k == SMB_CMD_WRITE);
      @(posedge clk_i);
    end
    if (len == 512)
      u_ctrl.send(SMB_CMD_TERMINATE, 1'b0, 13'h0000);
    #1;
    chk(beat_o.valid, 1'b0);
  endtask : burst

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(1'b0, SMB_OFS_BASE, 32'h0);
    chk(rd, 32'h20);
    wb(1'b0, SMB_OFS_EXT, 32'h0);
    chk(rd, 32'h0);
    chk(drive_level_o, SMB_LVL_FULL);
    chk(refresh_banks_o, 4'hf);
    wb(1'b1, SMB_OFS_BASE, 32'h1fff);
    wb(1'b0, SMB_OFS_BASE, 32'h0);
    chk(rd, 32'h20);
    wb(1'b0, 8'h10, 32'h0);
    chk(rd, 32'h0);
    for (i = 0; i < 3; i++)
      for (b = 0; b < 2; b++)
      begin
        u_ctrl.send(SMB_CMD_LOAD, 1'b0, md(1'b0, 2'h0, 3'h2, 1'(b), 3'(i + 1)));
        burst(b ? SMB_CMD_WRITE : SMB_CMD_READ, 9'h1f5, 2 << i, 1'(b), 2 << i);
      end
    u_ctrl.send(SMB_CMD_LOAD, 1'b0, md(1'b0, 2'h0, 3'h2, 1'b1, SMB_BL_1));
    burst(SMB_CMD_READ, 9'h0a3, 1, 1'b1, 1);
    u_ctrl.send(SMB_CMD_LOAD, 1'b0, md(1'b0, 2'h0, 3'h2, 1'b0, SMB_BL_PAGE));
    burst(SMB_CMD_READ, 9'h1fe, 512, 1'b0, 4);
    u_ctrl.send(SMB_CMD_LOAD, 1'b0, md(1'b0, 2'h0, 3'h2, 1'b1, SMB_BL_PAGE));
    burst(SMB_CMD_READ, 9'h010, 1, 1'b0, 0);
    for (i = 1; i < 4; i++)
    begin
      u_ctrl.send(SMB_CMD_LOAD, 1'b0, md(1'b0, 2'(i), 3'h2, 1'b0, SMB_BL_4));
      burst(SMB_CMD_READ, 9'h000, 4, 1'b0, 0);
    end
    wb(1'b0, SMB_OFS_STATUS, 32'h0);
    chk(rd, 32'h2);
    u_ctrl.send(SMB_CMD_LOAD, 1'b0, md(1'b1, 2'h0, 3'h2, 1'b0, SMB_BL_4));
    burst(SMB_CMD_WRITE, 9'h006, 1, 1'b0, 1);
    burst(SMB_CMD_READ, 9'h006, 4, 1'b0, 4);
    for (q = 1; q <= 3; q++)
    begin
      u_ctrl.send(SMB_CMD_LOAD, 1'b0, md(1'b0, 2'h0, 3'(q), 1'b0, SMB_BL_1));
      u_ctrl.send(SMB_CMD_READ, 1'b0, 13'h0077);
      for (i = 0; i <= q; i++)
      begin
        #1;
        chk(dq_drive_o, i + 1 == q - 1);
        chk(dq_valid_o, i + 1 == q);
        if (i + 1 == q)
          chk(dq_col_o, 9'h077);
        @(posedge clk_i);
      end
    end
    for (i = 0; i < 5; i++)
    begin
      u_ctrl.send(SMB_CMD_LOAD, 1'b1, 13'(i << 5));
      repeat (2) @(posedge clk_i);
      #1;
      chk(drive_level_o, lv[i]);
    end
    wb(1'b0, SMB_OFS_EXT, 32'h0);
    chk(rd, 32'h80);
    wb(1'b0, SMB_OFS_BASE, 32'h0);
    chk(rd, 32'h30);
    wb(1'b1, SMB_OFS_CTRL, 32'h1);
    wb(1'b0, SMB_OFS_CTRL, 32'h0);
    chk(rd, 32'h1);
    for (i = 0; i < 5; i++)
    begin
      u_ctrl.send(SMB_CMD_LOAD, 1'b1, {10'h000, pc[i]});
      wait_tick(n0);
      wait_tick(n0);
      chk({refresh_banks_o, refresh_rows_o}, pm[i]);
    end
    wait_tick(n0);
    @(posedge clk_i);
    temp_i <= 2'h3;
    wait_tick(n1);
    wait_tick(n1);
    chk(n1 < n0, 1'b1);
    close_out();
  end
endmodule : smb_sequencer_tb
`default_nettype wire
